// *** flash_bus_front.sv ***
// pin-level bus front end of a 16-bit parallel nor flash
// assumes the host drives bus pins synchronous to bus_clk in sync
// reads; array storage and command decoding sit outside on ref_clk
`timescale 1ns/100ps

module flash_bus_front #(
  parameter int ADDR_W = flash_bus_pkg::ADDR_W_512M
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    bus_clk,
  input  wire logic [ADDR_W-1:0]       addr_pin,
  input  wire logic [15:0]             dq_in,
  output logic      [15:0]             dq_out,
  output logic                         dq_oe,
  input  wire logic                    address_latch_strobe_n,
  input  wire logic                    die_select_n,
  input  wire logic                    die_output_enable_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    reset_pin_n,
  input  wire logic                    write_protect_n,
  input  wire logic                    vpp_ok,
  output logic                         wait_out,
  output logic                         wait_oe,
  output logic      [ADDR_W-1:0]       rd_addr,
  input  wire logic [15:0]             rd_data,
  output logic                         wr_valid,
  output logic      [ADDR_W-1:0]       wr_addr,
  output logic      [15:0]             wr_data,
  output logic                         alter_en,
  output logic                         automation_reset,
  output logic                         lockdown_active,
  output logic                         top_die_sel,
  input  wire logic                    cfg_load,
  input  wire logic [15:0]             cfg_value,
  output logic      [15:0]             read_config_register,
  output flash_bus_pkg::read_mode_t    read_mode
);

  localparam bit DUAL_DIE = (ADDR_W == flash_bus_pkg::ADDR_W_512M);
  localparam int SYNC_B   = flash_bus_pkg::CFG_SYNC_READ;
  localparam int POL_B    = flash_bus_pkg::CFG_WAIT_POL;

  // ---------------------------------------------------------------
  // core domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]               ce_s;
    logic [1:0]               oe_s;
    logic [2:0]               we_s;
    logic [2:0]               adv_s;
    logic [1:0]               rstp_s;
    logic [1:0]               wp_s;
    logic [1:0]               vpp_s;
    logic [1:0]               req_s;
    logic [ADDR_W-1:0]        a_s1;
    logic [ADDR_W-1:0]        a_s2;
    logic [15:0]              d_s1;
    logic [15:0]              d_s2;
    logic [ADDR_W-1:0]        alat;
    logic [15:0]              cfg;
    logic                     wr_v;
    logic                     alter;
    logic [ADDR_W-1:0]        wa;
    logic [15:0]              wd;
    logic [15:0]              dq_a;
    logic [ADDR_W-1:0]        ra;
    flash_bus_pkg::fetch_t    fst;
    logic                     req_done;
    logic [15:0]              xdata;
    logic                     brst;
  } core_st_t;

  // ---------------------------------------------------------------
  // bus clock domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]               rst_s;
    logic [1:0]               sync_s;
    logic [1:0]               ack_s;
    logic                     req;
    logic                     busy;
    logic                     valid;
    logic [ADDR_W-1:0]        baddr;
    logic [15:0]              dq;
  } bus_st_t;

  core_st_t core_reg;
  core_st_t core_next;
  bus_st_t  bus_reg;
  bus_st_t  bus_next;

  // ---------------------------------------------------------------
  // core domain next state
  // ---------------------------------------------------------------
  always_comb begin
    core_next        = core_reg;
    // every pin passes two flops before logic looks at it
    core_next.ce_s   = {core_reg.ce_s[0], die_select_n};
    core_next.oe_s   = {core_reg.oe_s[0], die_output_enable_n};
    core_next.we_s   = {core_reg.we_s[1:0], write_strobe_n};
    core_next.adv_s  = {core_reg.adv_s[1:0], address_latch_strobe_n};
    core_next.rstp_s = {core_reg.rstp_s[0], reset_pin_n};
    core_next.wp_s   = {core_reg.wp_s[0], write_protect_n};
    core_next.vpp_s  = {core_reg.vpp_s[0], vpp_ok};
    core_next.req_s  = {core_reg.req_s[0], bus_reg.req};
    core_next.a_s1   = addr_pin;
    core_next.a_s2   = core_reg.a_s1;
    core_next.d_s1   = dq_in;
    core_next.d_s2   = core_reg.d_s1;
    core_next.brst   = !core_reg.rstp_s[1];
    core_next.wr_v   = 1'b0;
    core_next.alter  = 1'b0;
    // flow through while low, frozen from the rising edge on
    if (!core_reg.adv_s[1]) begin
      core_next.alat = core_reg.a_s2;
    end
    // capture on write strobe rise; a held reset pin refuses it
    if (core_reg.we_s[1] && !core_reg.we_s[2] && !core_reg.ce_s[1]
        && core_reg.rstp_s[1]) begin
      core_next.wr_v  = 1'b1;
      core_next.wa    = core_reg.a_s2;
      core_next.wd    = core_reg.d_s2;
      core_next.alter = core_reg.vpp_s[1];
    end
    if (cfg_load && core_reg.rstp_s[1]) begin
      core_next.cfg = cfg_value;
    end
    case (core_reg.fst)
      flash_bus_pkg::FETCH_IDLE: begin
        core_next.ra   = core_reg.alat;
        core_next.dq_a = rd_data;
        if (core_reg.req_s[1] != core_reg.req_done) begin
          core_next.ra  = bus_reg.baddr;
          core_next.fst = flash_bus_pkg::FETCH_BUSY;
        end
      end
      flash_bus_pkg::FETCH_BUSY: begin
        // baddr is held by the bus side until the ack comes back
        core_next.xdata    = rd_data;
        core_next.req_done = core_reg.req_s[1];
        core_next.fst      = flash_bus_pkg::FETCH_IDLE;
      end
      default: begin
        core_next.fst = flash_bus_pkg::FETCH_IDLE;
      end
    endcase
    // pin reset returns to asynchronous array reads
    if (!core_reg.rstp_s[1]) begin
      core_next.cfg      = flash_bus_pkg::CFG_RESET;
      core_next.fst      = flash_bus_pkg::FETCH_IDLE;
      core_next.req_done = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_reg        <= '0;
      core_reg.ce_s   <= 2'h3;
      core_reg.oe_s   <= 2'h3;
      core_reg.we_s   <= 3'h7;
      core_reg.adv_s  <= 3'h0;
      // idle level of the pin, so no false reset pulse follows rst
      core_reg.rstp_s <= 2'h3;
      core_reg.wp_s   <= 2'h3;
      core_reg.cfg    <= flash_bus_pkg::CFG_RESET;
      core_reg.fst    <= flash_bus_pkg::FETCH_IDLE;
      core_reg.brst   <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  // ---------------------------------------------------------------
  // bus domain next state
  // ---------------------------------------------------------------
  always_comb begin
    bus_next        = bus_reg;
    bus_next.rst_s  = {bus_reg.rst_s[0], core_reg.brst};
    bus_next.sync_s = {bus_reg.sync_s[0], core_reg.cfg[SYNC_B]};
    bus_next.ack_s  = {bus_reg.ack_s[0], core_reg.req_done};
    if (bus_reg.rst_s[1]) begin
      bus_next.req   = 1'b0;
      bus_next.busy  = 1'b0;
      bus_next.valid = 1'b0;
    end else if (!bus_reg.sync_s[1] || die_select_n) begin
      bus_next.busy  = 1'b0;
      bus_next.valid = 1'b0;
    end else if (!address_latch_strobe_n) begin
      // strobe low at this edge: host logic moves it only on edges
      bus_next.baddr = addr_pin;
      bus_next.req   = !bus_reg.req;
      bus_next.busy  = 1'b1;
      bus_next.valid = 1'b0;
    end else if (bus_reg.busy) begin
      if (bus_reg.ack_s[1] == bus_reg.req) begin
        bus_next.dq    = core_reg.xdata;
        bus_next.busy  = 1'b0;
        bus_next.valid = 1'b1;
      end
    end else if (bus_reg.valid && !die_output_enable_n) begin
      // continuous burst: every shown word fetches the next one
      bus_next.baddr = ADDR_W'(bus_reg.baddr + 1'b1);
      bus_next.req   = !bus_reg.req;
      bus_next.busy  = 1'b1;
    end
  end

  // clock may stop between frames; a half-done fetch just waits
  always_ff @(posedge bus_clk) begin
    if (bus_reg.rst_s[1]) begin
      bus_reg       <= bus_next;
      bus_reg.dq    <= 16'h0000;
      bus_reg.baddr <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // ---------------------------------------------------------------
  // pins and user side
  // ---------------------------------------------------------------
  logic wait_act;

  assign dq_oe   = !die_select_n && !die_output_enable_n && write_strobe_n;
  assign wait_oe = !die_select_n && !die_output_enable_n;
  assign wait_act = bus_reg.busy && core_reg.cfg[SYNC_B] && write_strobe_n;
  assign wait_out = wait_oe && (wait_act ^ !core_reg.cfg[POL_B]);
  assign dq_out   = core_reg.cfg[SYNC_B] ? bus_reg.dq : core_reg.dq_a;

  assign rd_addr              = core_reg.ra;
  assign wr_valid             = core_reg.wr_v;
  assign wr_addr              = core_reg.wa;
  assign wr_data              = core_reg.wd;
  assign alter_en             = core_reg.alter;
  assign automation_reset     = !core_reg.rstp_s[1];
  assign lockdown_active      = !core_reg.wp_s[1];
  assign top_die_sel = DUAL_DIE ? core_reg.alat[ADDR_W-1] : 1'b0;
  assign read_config_register = core_reg.cfg;
  assign read_mode = core_reg.cfg[SYNC_B] ? flash_bus_pkg::MODE_SYNC
                                          : flash_bus_pkg::MODE_ASYNC;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking core_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence we_rise_q;
    core_reg.we_s[1] && !core_reg.we_s[2] && !core_reg.ce_s[1]
      && core_reg.rstp_s[1];
  endsequence

  sequence fetch_done_q;
    bus_reg.busy && !bus_reg.rst_s[1] && bus_reg.sync_s[1]
      && !die_select_n && address_latch_strobe_n
      && bus_reg.ack_s[1] == bus_reg.req;
  endsequence

  dq_float_a: assert property (
    (die_select_n || die_output_enable_n) |-> !dq_oe)
    else $error("data pins driven while deselected");
  wait_float_a: assert property (
    (die_select_n || die_output_enable_n) |-> !wait_oe && !wait_out)
    else $error("wait driven while deselected");
  write_take_a: assert property (
    we_rise_q |=> wr_valid && wr_data == $past(core_reg.d_s2)
      && wr_addr == $past(core_reg.a_s2))
    else $error("write strobe rise not captured");
  write_block_a: assert property (
    !core_reg.rstp_s[1] |=> !wr_valid)
    else $error("write accepted under reset pin");
  vpp_guard_a: assert property (
    alter_en |-> wr_valid && $past(core_reg.vpp_s[1]))
    else $error("array altered at supply lockout");
  reset_async_a: assert property (
    $rose(core_reg.rstp_s[1]) |-> read_mode == flash_bus_pkg::MODE_ASYNC)
    else $error("reset exit not in async mode");
  addr_flow_a: assert property (
    !core_reg.adv_s[1] |=> core_reg.alat == $past(core_reg.a_s2))
    else $error("address not flowing through");
  addr_hold_a: assert property (
    core_reg.adv_s[1] |=> $stable(core_reg.alat))
    else $error("latched address moved");
  async_wait_a: assert property (
    wait_oe && !core_reg.cfg[SYNC_B] |-> wait_out == !core_reg.cfg[POL_B])
    else $error("wait asserted outside sync reads");
  sync_latch_a: assert property (@(posedge bus_clk)
    disable iff (bus_reg.rst_s[1])
    bus_reg.sync_s[1] && !die_select_n && !address_latch_strobe_n
      |=> bus_reg.busy && bus_reg.baddr == $past(addr_pin))
    else $error("sync address not latched");
  wait_clear_a: assert property (@(posedge bus_clk)
    disable iff (bus_reg.rst_s[1])
    fetch_done_q |=> !bus_reg.busy && bus_reg.valid)
    else $error("wait held after data valid");

  // ---------------------------------------------------------------
  // pin level and burst step checks
  // ---------------------------------------------------------------
  // a shown word with output enable low fetches the next address
  sequence word_shown_q;
    !bus_reg.busy && bus_reg.valid && bus_reg.sync_s[1]
      && !die_select_n && !die_output_enable_n
      && address_latch_strobe_n;
  endsequence

  dq_drive_a: assert property (
    (!die_select_n && !die_output_enable_n && write_strobe_n) |-> dq_oe)
    else $error("data pins not driven during read");
  wait_pol_a: assert property (
    wait_oe && wait_act |-> wait_out == core_reg.cfg[POL_B])
    else $error("wait asserted at wrong polarity");
  top_die_a: assert property (
    (DUAL_DIE && !address_latch_strobe_n) [*4]
      |-> top_die_sel == $past(addr_pin[ADDR_W-1], 3))
    else $error("die select bit not from top address");
  auto_reset_a: assert property (
    !reset_pin_n [*3] |-> automation_reset)
    else $error("automation not held in reset");
  lock_on_a: assert property (
    !write_protect_n [*3] |-> lockdown_active)
    else $error("lock-down not active with protect low");
  lock_off_a: assert property (
    write_protect_n [*3] |-> !lockdown_active)
    else $error("lock-down not overridden with protect high");
  cfg_clear_a: assert property (
    !core_reg.rstp_s[1]
      |=> read_config_register == flash_bus_pkg::CFG_RESET)
    else $error("read configuration kept under reset pin");
  wr_pulse_a: assert property (
    wr_valid |=> !wr_valid)
    else $error("write pulse longer than one cycle");
  alter_block_a: assert property (
    wr_valid && !$past(core_reg.vpp_s[1]) |-> !alter_en)
    else $error("alter allowed at supply lockout");
  burst_step_a: assert property (@(posedge bus_clk)
    disable iff (bus_reg.rst_s[1])
    word_shown_q |=> bus_reg.busy
      && bus_reg.baddr == ADDR_W'($past(bus_reg.baddr) + 1'b1))
    else $error("burst did not step to next address");
  sync_idle_a: assert property (@(posedge bus_clk)
    disable iff (bus_reg.rst_s[1])
    !bus_reg.sync_s[1] || die_select_n |=> !bus_reg.busy && !bus_reg.valid)
    else $error("bus side active outside sync frames");

endmodule

// *** flash_bus_pkg.sv ***
// shared constants and types of the parallel flash bus front end
// assumes one core clock domain and one bus clock domain around it
package flash_bus_pkg;

  // ---------------------------------------------------------------
  // address width by density
  // ---------------------------------------------------------------
  localparam int ADDR_W_64M  = 22;
  localparam int ADDR_W_128M = 23;
  localparam int ADDR_W_256M = 24;
  localparam int ADDR_W_512M = 25;

  // ---------------------------------------------------------------
  // bus and read configuration layout
  // ---------------------------------------------------------------
  localparam int DATA_W         = 16;
  localparam int CFG_WAIT_POL   = 10;
  localparam int CFG_SYNC_READ  = 15;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  typedef enum logic {MODE_ASYNC, MODE_SYNC} read_mode_t;
  typedef enum logic {FETCH_IDLE, FETCH_BUSY} fetch_t;

endpackage

// *** host_bus_model.sv ***
// host memory controller model that drives the flash bus pins
// assumes a core clock on ref_clk; bus_clk only runs while bus_run is set: during rst and inside sync frames
`timescale 1ns/100ps

module host_bus_model (
  input  wire logic        ref_clk,
  output logic             bus_clk,
  output logic [24:0]      addr_pin,
  output logic [15:0]      host_dq,
  output logic             host_drv,
  output logic             address_latch_strobe_n,
  output logic             die_select_n,
  output logic             die_output_enable_n,
  output logic             write_strobe_n
);
  logic bus_run;

  initial begin
    bus_run = 1'b0;
    addr_pin = 25'h0000000;
    host_dq = 16'h0000;
    host_drv = 1'b0;
    address_latch_strobe_n = 1'b0;
    die_select_n = 1'b1;
    die_output_enable_n = 1'b1;
    write_strobe_n = 1'b1;
  end

  // odd start offset keeps the link clock out of phase with ref_clk
  initial begin
    bus_clk = 1'b0;
    #7;
    forever begin
      #15;
      bus_clk = bus_run ? ~bus_clk : 1'b0;
    end
  end

  task automatic run_clock(input logic on);
    @(posedge ref_clk);
    bus_run <= on;
  endtask

  task automatic set_pins(input logic [24:0] a, input logic ls_n,
                          input logic cs_n, input logic oe_n);
    @(posedge ref_clk);
    addr_pin <= a;
    address_latch_strobe_n <= ls_n;
    die_select_n <= cs_n;
    die_output_enable_n <= oe_n;
  endtask

  task automatic write_word(input logic [24:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr_pin <= a;
    host_dq <= d;
    host_drv <= 1'b1;
    die_select_n <= 1'b0;
    write_strobe_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    write_strobe_n <= 1'b1;
    // select stays low until the synced strobe rise has been seen
    repeat (3) @(posedge ref_clk);
    die_select_n <= 1'b1;
    host_drv <= 1'b0;
  endtask

  task automatic sync_start(input logic [24:0] a);
    @(posedge ref_clk);
    bus_run <= 1'b1;
    // bus side must leave reset and see sync mode before the strobe
    repeat (4) @(posedge bus_clk);
    addr_pin <= a;
    address_latch_strobe_n <= 1'b0;
    die_select_n <= 1'b0;
    die_output_enable_n <= 1'b0;
    @(posedge bus_clk);
    address_latch_strobe_n <= 1'b1;
  endtask

  task automatic sync_stop();
    @(posedge bus_clk);
    die_select_n <= 1'b1;
    die_output_enable_n <= 1'b1;
    address_latch_strobe_n <= 1'b0;
    bus_run <= 1'b0;
  endtask
endmodule

// *** test_flash_parallel_bus_interface.sv ***
// self-checking bench for the parallel flash bus front end
// assumes host_bus_model drives the pins and a comb array answers rd_addr
`timescale 1ns/100ps

module test_flash_parallel_bus_interface;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        bus_clk, host_drv, ls_n, cs_n, oe_n, we_n;
  logic [24:0] addr_pin, rd_addr, wr_addr, cap_addr;
  logic [15:0] host_dq, dq_in, dq_out, rd_data, wr_data, cap_data, cfg;
  logic        dq_oe, wait_out, wait_oe, wr_valid, alter_en, auto_rst;
  logic        lockdown_active, top_die_sel, cap_alter;
  logic        reset_pin_n = 1'b1;
  logic        write_protect_n = 1'b1;
  logic        vpp_ok = 1'b1;
  logic        cfg_load = 1'b0;
  logic [15:0] cfg_value = 16'h0000;
  flash_bus_pkg::read_mode_t read_mode;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_wr = 0;

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [15:0] arr(input logic [24:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  assign rd_data = arr(rd_addr);
  // released data lines show dq_out while dq_oe is high, else the inverse of the last host value
  assign dq_in = host_drv ? host_dq : (dq_oe ? dq_out : ~host_dq);

  host_bus_model u_host (.ref_clk(ref_clk), .bus_clk(bus_clk),
    .addr_pin(addr_pin), .host_dq(host_dq), .host_drv(host_drv),
    .address_latch_strobe_n(ls_n), .die_select_n(cs_n),
    .die_output_enable_n(oe_n), .write_strobe_n(we_n));

  flash_bus_front u_dut (.ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk),
    .addr_pin(addr_pin), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .address_latch_strobe_n(ls_n), .die_select_n(cs_n),
    .die_output_enable_n(oe_n), .write_strobe_n(we_n),
    .reset_pin_n(reset_pin_n), .write_protect_n(write_protect_n),
    .vpp_ok(vpp_ok), .wait_out(wait_out), .wait_oe(wait_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .alter_en(alter_en),
    .automation_reset(auto_rst), .lockdown_active(lockdown_active),
    .top_die_sel(top_die_sel), .cfg_load(cfg_load), .cfg_value(cfg_value),
    .read_config_register(cfg), .read_mode(read_mode));

  // capture the one-cycle write pulse whenever it comes
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      cap_addr <= wr_addr;
      cap_data <= wr_data;
      cap_alter <= alter_en;
    end
  end

  task automatic chk_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_word(input string what, input logic [24:0] e,
                          input logic [24:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_enables();
    for (int i = 0; i < 4; i++) begin
      u_host.set_pins(25'h0000123, 1'b0, i[1], i[0]);
      repeat (3) @(posedge ref_clk);
      #1;
      chk_bit("dq_oe", i == 0, dq_oe);
      chk_bit("wait_oe", i == 0, wait_oe);
      chk_bit("wait_out", i == 0, wait_out);
    end
  endtask

  task automatic t_async();
    u_host.set_pins(25'h1ABCDEF, 1'b0, 1'b0, 1'b0);
    repeat (7) @(posedge ref_clk);
    #1;
    chk_word("rd_addr", 25'h1ABCDEF, rd_addr);
    chk_word("dq_out", arr(25'h1ABCDEF), dq_out);
    chk_bit("top_die_sel", 1'b1, top_die_sel);
    u_host.set_pins(25'h1ABCDEF, 1'b1, 1'b0, 1'b0);
    u_host.set_pins(25'h0012345, 1'b1, 1'b0, 1'b0);
    repeat (7) @(posedge ref_clk);
    #1;
    chk_word("latched rd_addr", 25'h1ABCDEF, rd_addr);
    u_host.set_pins(25'h0012345, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic t_write();
    for (int v = 1; v >= 0; v--) begin
      @(posedge ref_clk);
      vpp_ok <= v[0];
      u_host.write_word(25'h0F0F0F0 + v, 16'hC3A5 ^ v[15:0]);
      @(posedge ref_clk);
      #1;
      chk_word("writes", 2 - v, n_wr);
      chk_word("wr_addr", 25'h0F0F0F0 + v, cap_addr);
      chk_word("wr_data", 16'hC3A5 ^ v, {9'h000, cap_data});
      chk_bit("alter_en", v[0], cap_alter);
      chk_bit("top_die_sel low", 1'b0, top_die_sel);
    end
    @(posedge ref_clk);
    vpp_ok <= 1'b1;
  endtask

  task automatic wait_level(input logic lvl);
    int k;
    for (k = 0; k < 60 && wait_out !== lvl; k++) begin
      @(posedge bus_clk);
      #1;
    end
    chk_bit("wait_out", lvl, wait_out);
  endtask

  task automatic t_sync();
    @(posedge ref_clk);
    cfg_load <= 1'b1;
    cfg_value <= 16'h8400;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_bit("sync", 1, read_mode == flash_bus_pkg::MODE_SYNC);
    u_host.sync_start(25'h0000400);
    wait_level(1'b1);
    wait_level(1'b0);
    chk_word("burst 0", arr(25'h0000400), dq_out);
    wait_level(1'b1);
    wait_level(1'b0);
    chk_word("burst 1", arr(25'h0000401), dq_out);
    u_host.sync_stop();
    repeat (2) @(posedge ref_clk);
    chk_bit("wait_oe idle", 1'b0, wait_oe);
  endtask

  task automatic t_pin_reset();
    reset_pin_n <= 1'b0;
    write_protect_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_bit("automation_reset", 1'b1, auto_rst);
    chk_bit("lockdown_active", 1'b1, lockdown_active);
    u_host.write_word(25'h0000055, 16'h1234);
    repeat (3) @(posedge ref_clk);
    chk_word("blocked writes", 2, n_wr);
    reset_pin_n <= 1'b1;
    write_protect_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_bit("async", 1, read_mode == flash_bus_pkg::MODE_ASYNC);
    chk_word("cfg", flash_bus_pkg::CFG_RESET, {9'h000, cfg});
    chk_bit("lockdown off", 1'b0, lockdown_active);
  endtask

  initial begin
    u_host.run_clock(1'b1);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    u_host.run_clock(1'b0);
    repeat (4) @(posedge ref_clk);
    #1;
    chk_word("cfg0", flash_bus_pkg::CFG_RESET, {9'h000, cfg});
    t_enables();
    t_async();
    t_write();
    t_sync();
    t_pin_reset();
    test_done();
  end

  // a healthy run takes well under 1000 core cycles
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
